//--- flash_array_mem.sv
// Dual clock byte array: write port on the core clock, registered read on the link clock.
// Assumes the array starts undefined until erased.
`timescale 1ns/1ps
`default_nettype none
module flash_array_mem #(
   parameter int AW = 19,
   parameter int DW = 8
) (
   input wire logic wclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic rclk,
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] cells [0:(1<<AW)-1];
   logic [DW-1:0] rdata_ff;

   always_ff @(posedge wclk) begin
      if (we) begin
         cells[waddr] <= wdata;
      end
   end

   always_ff @(posedge rclk) begin
      if (re) begin
         rdata_ff <= cells[raddr];
      end
   end

   assign rdata = rdata_ff;
endmodule : flash_array_mem
`default_nettype wire

//--- flash_cmd_pkg.sv
// Constants and carrier types of the serial flash command sequencer.
// Assumes a four-wire link with byte-wide bus cycles, most significant bit first.
//
// Overview of operation
// - Every opcode, address, dummy or data cycle is exactly eight serial clocks.
// - Address bits above the array density are ignored by the device.
// - Opcode 03h plus three address bytes streams data from that address.
// - Reads stream continuously, pointer increments and wraps to zero until select rises.
// - Opcode 0bh takes three address bytes and one dummy byte before data.
// - Opcode 02h takes three address bytes and exactly one data byte.
// - Byte program into a protected region is ignored.
// - Program starts only when select rises after the data byte; busy shows it.
// - Sector erase 20h selects the 4 KByte sector by address bits down to 12.
// - Block erase 52h uses bits down to 15, d8h down to 16.
// - Opcodes 60h and c7h both erase the whole array, no address.
// - After 05h the status byte repeats every byte until select rises.
// - Ident read 90h or abh gives maker code on even, part code on odd address.
// - Auto-increment program: adh, address, two bytes; later adh plus two bytes.
// - First auto-increment byte goes to even address, second to odd.
// - 70h enables busy reporting on serial output in auto-increment mode; 80h disables.
// - Frame starts at select falling; input sampled on rising clock, msb first.
// - Status bit 0 is one while program or erase runs.
// - Write enable latch clears after byte program, erase, write disable and power-up; auto-increment program keeps it set.
package flash_cmd_pkg;

   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_BYTE_PROG = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_IDENT_A = 8'h90;
   localparam logic [7:0] OP_IDENT_B = 8'hab;
   localparam logic [7:0] OP_AUTO_INC = 8'had;
   localparam logic [7:0] OP_BUSY_OUT_EN = 8'h70;
   localparam logic [7:0] OP_BUSY_OUT_DIS = 8'h80;

   // Frame lengths in whole bytes, opcode included
   localparam logic [2:0] LEN_BARE = 3'h1;
   localparam logic [2:0] LEN_ADDR_CMD = 3'h4;
   localparam logic [2:0] LEN_BYTE_PROG = 3'h5;
   localparam logic [2:0] LEN_AAI_FIRST = 3'h6;
   localparam logic [2:0] LEN_AAI_NEXT = 3'h3;
   localparam logic [2:0] LEN_NONE = 3'h0;
   localparam logic [2:0] IDX_LAST_ADDR = 3'h3;
   localparam logic [2:0] IDX_DUMMY = 3'h4;
   localparam logic [2:0] IDX_DATA_FIRST = 3'h4;
   localparam logic [2:0] IDX_DATA_NEXT = 3'h1;

   localparam int SECTOR_SHIFT = 12;
   localparam int BLOCK32_SHIFT = 15;
   localparam int BLOCK64_SHIFT = 16;
   localparam int ADDR_W_DEFAULT = 19;

   localparam int ST_BUSY = 0;
   localparam int ST_WEL = 1;
   localparam int ST_PROT_LO = 2;
   localparam int ST_AAI = 6;
   localparam int ST_RB_EN = 8;

   localparam logic [7:0] ERASED_BYTE = 8'hff;
   // Identity codes: arbitrary values
   localparam logic [7:0] MAKER_CODE = 8'h5a;
   localparam logic [7:0] PART_CODE = 8'h3c;

   localparam int CORE_CLK_MHZ = 250;
   localparam int BYTE_PROGRAM_TIME_NS = 10000;
   localparam int BYTE_PROGRAM_CYC = (BYTE_PROGRAM_TIME_NS * CORE_CLK_MHZ + 999) / 1000;

   typedef struct packed {
      logic ok;
      logic [7:0] op;
      logic [23:0] addr;
      logic [7:0] data0;
      logic [7:0] data1;
   } linkCmd_t;

endpackage : flash_cmd_pkg

//--- spi_flash_command_set.sv
// Serial flash command sequencer: link shifter on sck, array engine on core_clk.
// Assumes select_n high between frames and sck idle outside frames.
`timescale 1ns/1ps
`default_nettype none
module spi_flash_command_set
   import flash_cmd_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEFAULT,
   parameter int PROG_CYC = BYTE_PROGRAM_CYC,
   parameter logic [7:0] MAKER_ID = MAKER_CODE,
   parameter logic [7:0] PART_ID = PART_CODE
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic sck,
   input wire logic select_n,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutEn,
   input wire logic [2:0] protLevel,
   output logic busyStatus
);
   typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE, ST_WAIT} engState_t;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   logic [1:0] rstPipe_ff;
   logic rstSync_n;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstPipe_ff <= 2'h0;
      end else begin
         rstPipe_ff <= {rstPipe_ff[0], 1'b1};
      end
   end
   assign rstSync_n = rstPipe_ff[1];

   ////////////////////////////////////////////////////////////////////////////
   // Link domain
   logic [2:0] bitCnt_ff, byteCnt_ff;
   logic [6:0] shift_ff;
   logic outPhase_ff;
   logic cmdOk_ff;
   logic [7:0] op_ff, data0_ff, data1_ff, outHold_ff;
   logic [23:0] addr_ff;
   logic [ADDR_W-1:0] ptr_ff;
   logic soBit_ff, soActive_ff;
   logic [8:0] coreStat;
   logic [8:0] linkStat;
   logic [7:0] rdData;

   function automatic logic [2:0] cmdLen(input logic [7:0] op, input logic auto_increment_program);
      case (op)
         OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE: cmdLen = LEN_ADDR_CMD;
         OP_BYTE_PROG: cmdLen = LEN_BYTE_PROG;
         OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_WRITE_ENABLE, OP_WRITE_DISABLE,
         OP_BUSY_OUT_EN, OP_BUSY_OUT_DIS: cmdLen = LEN_BARE;
         OP_AUTO_INC: cmdLen = auto_increment_program ? LEN_AAI_NEXT : LEN_AAI_FIRST;
         default: cmdLen = LEN_NONE;
      endcase
   endfunction : cmdLen

   wire logic byteDone = (bitCnt_ff == 3'h7);
   wire logic [7:0] nxtByte = {shift_ff, serialIn};
   wire logic [7:0] opNow = (byteCnt_ff == 3'h0) ? nxtByte : op_ff;
   wire logic aaiL = linkStat[ST_AAI];
   wire logic rbOnL = linkStat[ST_RB_EN];
   wire logic [2:0] byteCntInc = (byteCnt_ff == 3'h7) ? 3'h7 : 3'(byteCnt_ff + 3'h1);
   wire logic [2:0] needLen = cmdLen(opNow, aaiL);
   wire logic inAddr = (byteCnt_ff != 3'h0) && (byteCnt_ff <= IDX_LAST_ADDR);
   wire logic [23:0] addrNext = inAddr ? {addr_ff[15:0], nxtByte} : addr_ff;
   wire logic isReadOp = (op_ff == OP_READ) || (op_ff == OP_FAST_READ);
   wire logic isIdentOp = (op_ff == OP_IDENT_A) || (op_ff == OP_IDENT_B);
   wire logic readStart = byteDone && !aaiL &&
      (((opNow == OP_READ) && (byteCnt_ff == IDX_LAST_ADDR)) ||
       ((opNow == OP_FAST_READ) && (byteCnt_ff == IDX_DUMMY)));
   wire logic statStart = byteDone && (byteCnt_ff == 3'h0) && (nxtByte == OP_STATUS_READ) &&
      !(aaiL && rbOnL);
   wire logic identStart = byteDone && !aaiL && isIdentOp && (byteCnt_ff == IDX_LAST_ADDR);
   wire logic rdEn = readStart || (byteDone && outPhase_ff && isReadOp);
   wire logic [ADDR_W-1:0] rdAddr = readStart ? addrNext[ADDR_W-1:0] : ptr_ff;
   wire logic nxt_outPhase = outPhase_ff || readStart || statStart || identStart;
   wire logic nxt_cmdOk = byteDone && (needLen != LEN_NONE) && (byteCntInc == needLen);
   wire logic aaiCont = (opNow == OP_AUTO_INC) && aaiL;
   wire logic [2:0] dataBase = aaiCont ? IDX_DATA_NEXT : IDX_DATA_FIRST;
   wire logic [7:0] nxt_op = (byteDone && (byteCnt_ff == 3'h0)) ? nxtByte : op_ff;
   wire logic [23:0] nxt_addr = byteDone ? addrNext : addr_ff;
   wire logic [7:0] nxt_data0 = (byteDone && (byteCnt_ff == dataBase)) ? nxtByte : data0_ff;
   wire logic [7:0] nxt_data1 = (byteDone && (byteCnt_ff == 3'(dataBase + 3'h1))) ? nxtByte : data1_ff;
   wire logic [ADDR_W-1:0] nxt_ptr = rdEn ? ADDR_W'(rdAddr + 1'b1) : ptr_ff;
   wire logic [7:0] holdVal = (opNow == OP_STATUS_READ) ? linkStat[7:0] :
      (addrNext[0] ? PART_ID : MAKER_ID);
   wire logic [7:0] nxt_outHold = byteDone ? holdVal : outHold_ff;
   wire logic [7:0] outByte = isReadOp ? rdData : outHold_ff;

   // Frame counters, cleared the moment select rises
   always_ff @(posedge sck or posedge select_n) begin
      if (select_n) begin
         bitCnt_ff <= 3'h0;
         byteCnt_ff <= 3'h0;
         shift_ff <= 7'h00;
         outPhase_ff <= 1'b0;
      end else begin
         bitCnt_ff <= 3'(bitCnt_ff + 3'h1);
         byteCnt_ff <= byteDone ? byteCntInc : byteCnt_ff;
         shift_ff <= nxtByte[6:0];
         outPhase_ff <= nxt_outPhase;
      end
   end

   // Command capture, held after the frame for the core to pick up
   always_ff @(posedge sck or negedge rstSync_n) begin
      if (!rstSync_n) begin
         cmdOk_ff <= 1'b0;
         op_ff <= 8'h00;
         addr_ff <= 24'h000000;
         data0_ff <= 8'h00;
         data1_ff <= 8'h00;
         ptr_ff <= '0;
         outHold_ff <= 8'h00;
      end else begin
         cmdOk_ff <= nxt_cmdOk;
         op_ff <= nxt_op;
         addr_ff <= nxt_addr;
         data0_ff <= nxt_data0;
         data1_ff <= nxt_data1;
         ptr_ff <= nxt_ptr;
         outHold_ff <= nxt_outHold;
      end
   end

   // Output bits change on the falling clock
   always_ff @(negedge sck or posedge select_n) begin
      if (select_n) begin
         soBit_ff <= 1'b0;
         soActive_ff <= 1'b0;
      end else begin
         soBit_ff <= outByte[3'(3'h7 - bitCnt_ff)];
         soActive_ff <= outPhase_ff;
      end
   end

   sync_2ff #(.W(9), .RST_VAL(9'h000)) u_statToLink (
      .clk(sck),
      .rst_n(rstSync_n),
      .d(coreStat),
      .q(linkStat)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Core domain
   engState_t state_ff, nxt_state;
   logic csSync, csPrev_ff;
   logic [2:0] protSync;
   logic wel_ff, aaiMode_ff, rbEn_ff, wrHi_ff, wrTwo_ff;
   logic [ADDR_W-1:0] wrPtr_ff, endPtr_ff;
   logic [7:0] d0_ff, d1_ff;
   logic [23:0] timer_ff;
   linkCmd_t cmd;

   sync_2ff #(.W(1), .RST_VAL(1'b1)) u_selToCore (
      .clk(core_clk),
      .rst_n(rstSync_n),
      .d(select_n),
      .q(csSync)
   );

   sync_2ff #(.W(3), .RST_VAL(3'h7)) u_protToCore (
      .clk(core_clk),
      .rst_n(rstSync_n),
      .d(protLevel),
      .q(protSync)
   );

   function automatic logic protHit(input logic [2:0] lvl, input logic [ADDR_W-1:0] a);
      logic [2:0] top;
      top = a[ADDR_W-1 -: 3];
      protHit = lvl[2] || ((lvl == 3'h1) && (top == 3'h7)) ||
         ((lvl == 3'h2) && (top >= 3'h6)) || ((lvl == 3'h3) && (top >= 3'h4));
   endfunction : protHit

   assign cmd = '{ok: cmdOk_ff, op: op_ff, addr: addr_ff, data0: data0_ff, data1: data1_ff};

   wire logic busy = (state_ff != ST_IDLE);
   wire logic csRise = csSync && !csPrev_ff;
   wire logic frameCmd = csRise && cmd.ok;
   wire logic [ADDR_W-1:0] cmdAddr = cmd.addr[ADDR_W-1:0];
   wire logic [ADDR_W-1:0] aaiNext = ADDR_W'(wrPtr_ff + 1'b1);
   wire logic writeOk = wel_ff && !busy;
   wire logic isSector = cmd.op == OP_SECTOR_ERASE;
   wire logic isBlk32 = cmd.op == OP_BLOCK32_ERASE;
   wire logic isBlk64 = cmd.op == OP_BLOCK64_ERASE;
   wire logic isChip = (cmd.op == OP_CHIP_ERASE_A) || (cmd.op == OP_CHIP_ERASE_B);
   wire logic goProg = frameCmd && (cmd.op == OP_BYTE_PROG) && writeOk && !aaiMode_ff &&
      !protHit(protSync, cmdAddr);
   wire logic goAaiFirst = frameCmd && (cmd.op == OP_AUTO_INC) && writeOk && !aaiMode_ff &&
      !protHit(protSync, cmdAddr);
   wire logic goAaiNext = frameCmd && (cmd.op == OP_AUTO_INC) && writeOk && aaiMode_ff &&
      (aaiNext != '0) && !protHit(protSync, aaiNext);
   wire logic goBlock = frameCmd && (isSector || isBlk32 || isBlk64) && writeOk && !aaiMode_ff &&
      !protHit(protSync, cmdAddr);
   wire logic goChip = frameCmd && isChip && writeOk && !aaiMode_ff && (protSync == 3'h0);
   wire logic [ADDR_W-1:0] eraseMask = isSector ? ADDR_W'((1 << SECTOR_SHIFT) - 1) :
      isBlk32 ? ADDR_W'((1 << BLOCK32_SHIFT) - 1) : ADDR_W'((1 << BLOCK64_SHIFT) - 1);
   wire logic doWrDis = frameCmd && (cmd.op == OP_WRITE_DISABLE);
   wire logic doWrEn = frameCmd && (cmd.op == OP_WRITE_ENABLE) && !aaiMode_ff;
   wire logic eraseLast = (state_ff == ST_ERASE) && (wrPtr_ff == endPtr_ff);
   wire logic progLast = (state_ff == ST_PROG) && (!wrTwo_ff || wrHi_ff);
   wire logic waitDone = (state_ff == ST_WAIT) && (timer_ff == 24'h000000);
   wire logic opDone = eraseLast || (waitDone && !aaiMode_ff);
   wire logic memWe = (state_ff == ST_PROG) || (state_ff == ST_ERASE);
   wire logic [7:0] memWdata = (state_ff == ST_ERASE) ? ERASED_BYTE : (wrHi_ff ? d1_ff : d0_ff);
   wire logic nxt_wel = doWrEn ? 1'b1 : ((opDone || doWrDis) ? 1'b0 : wel_ff);
   wire logic nxt_aaiMode = goAaiFirst ? 1'b1 : (doWrDis ? 1'b0 : aaiMode_ff);
   wire logic nxt_rbEn = (frameCmd && (cmd.op == OP_BUSY_OUT_EN)) ? 1'b1 :
      ((frameCmd && (cmd.op == OP_BUSY_OUT_DIS)) ? 1'b0 : rbEn_ff);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (goProg || goAaiFirst || goAaiNext) begin
               nxt_state = ST_PROG;
            end else if (goBlock || goChip) begin
               nxt_state = ST_ERASE;
            end
         end
         ST_PROG: begin
            if (progLast) begin
               nxt_state = ST_WAIT;
            end
         end
         ST_ERASE: begin
            if (eraseLast) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (waitDone) begin
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   wire logic [ADDR_W-1:0] nxt_wrPtr =
      (goProg) ? cmdAddr :
      (goAaiFirst) ? {cmdAddr[ADDR_W-1:1], 1'b0} :
      (goAaiNext) ? aaiNext :
      (goChip) ? '0 :
      (goBlock) ? (cmdAddr & ~eraseMask) :
      (memWe && !eraseLast && !progLast) ? ADDR_W'(wrPtr_ff + 1'b1) : wrPtr_ff;
   wire logic [ADDR_W-1:0] nxt_endPtr = goChip ? '1 : (goBlock ? (cmdAddr | eraseMask) : endPtr_ff);
   wire logic nxt_wrHi = (state_ff == ST_PROG) ? !wrHi_ff : 1'b0;
   wire logic nxt_wrTwo = (goAaiFirst || goAaiNext) ? 1'b1 : (goProg ? 1'b0 : wrTwo_ff);
   wire logic startAny = goProg || goAaiFirst || goAaiNext;
   wire logic [23:0] nxt_timer = progLast ? 24'(PROG_CYC - 1) :
      ((state_ff == ST_WAIT) ? 24'(timer_ff - 24'h000001) : timer_ff);

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_ff <= ST_IDLE;
         csPrev_ff <= 1'b1;
         wel_ff <= 1'b0;
         aaiMode_ff <= 1'b0;
         rbEn_ff <= 1'b0;
         wrPtr_ff <= '0;
         endPtr_ff <= '0;
         wrHi_ff <= 1'b0;
         wrTwo_ff <= 1'b0;
         timer_ff <= 24'h000000;
         d0_ff <= 8'h00;
         d1_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         csPrev_ff <= csSync;
         wel_ff <= nxt_wel;
         aaiMode_ff <= nxt_aaiMode;
         rbEn_ff <= nxt_rbEn;
         wrPtr_ff <= nxt_wrPtr;
         endPtr_ff <= nxt_endPtr;
         wrHi_ff <= nxt_wrHi;
         wrTwo_ff <= nxt_wrTwo;
         timer_ff <= nxt_timer;
         d0_ff <= startAny ? cmd.data0 : d0_ff;
         d1_ff <= startAny ? cmd.data1 : d1_ff;
      end
   end

   flash_array_mem #(.AW(ADDR_W), .DW(8)) u_array (
      .wclk(core_clk),
      .we(memWe),
      .waddr(wrPtr_ff),
      .wdata(memWdata),
      .rclk(sck),
      .re(rdEn),
      .raddr(rdAddr),
      .rdata(rdData)
   );

   assign coreStat = {rbEn_ff, 1'b0, aaiMode_ff, 1'b0, protSync, wel_ff, busy};

   ////////////////////////////////////////////////////////////////////////////
   // Pins
   wire logic rbDrive = rbEn_ff && aaiMode_ff;
   assign serialOutEn = !select_n && (soActive_ff || rbDrive);
   assign serialOut = rbDrive ? !busy : soBit_ff;
   assign busyStatus = busy;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_prog_entry;
      (state_ff == ST_PROG) && !wrHi_ff && !wrPtr_ff[0];
   endsequence
   sequence s_prog_odd;
      (state_ff == ST_PROG) && wrHi_ff && wrPtr_ff[0];
   endsequence

   property p_no_wel;
      @(posedge core_clk) disable iff (!rstSync_n)
      (frameCmd && !wel_ff && !busy && ((cmd.op == OP_BYTE_PROG) || isChip || isSector)) |=> !busy;
   endproperty
   a_no_wel: assert property (p_no_wel) else $error("write op ran without enable latch");

   property p_start_on_select;
      @(posedge core_clk) disable iff (!rstSync_n)
      $rose(busy) |-> $past(csRise);
   endproperty
   a_start_on_select: assert property (p_start_on_select) else $error("busy rose without select rise");

   property p_wel_clear;
      @(posedge core_clk) disable iff (!rstSync_n)
      ($fell(busy) && !aaiMode_ff) |-> !wel_ff;
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("enable latch kept after operation");

   property p_protect;
      @(posedge core_clk) disable iff (!rstSync_n)
      (frameCmd && (cmd.op == OP_BYTE_PROG) && protHit(protSync, cmdAddr)) |=> !busy;
   endproperty
   a_protect: assert property (p_protect) else $error("protected byte program started");

   property p_chip;
      @(posedge core_clk) disable iff (!rstSync_n)
      goChip |=> (state_ff == ST_ERASE) && (wrPtr_ff == '0) && (endPtr_ff == '1);
   endproperty
   a_chip: assert property (p_chip) else $error("chip erase range wrong");

   property p_sector;
      @(posedge core_clk) disable iff (!rstSync_n)
      (goBlock && isSector) |=> ((wrPtr_ff & ADDR_W'((1 << SECTOR_SHIFT) - 1)) == '0) &&
         ((endPtr_ff | ~ADDR_W'((1 << SECTOR_SHIFT) - 1)) == '1);
   endproperty
   a_sector: assert property (p_sector) else $error("sector range wrong");

   property p_aai_order;
      @(posedge core_clk) disable iff (!rstSync_n)
      (goAaiFirst || goAaiNext) |=> s_prog_entry ##1 s_prog_odd;
   endproperty
   a_aai_order: assert property (p_aai_order) else $error("word bytes out of order");

   property p_busy_bit;
      @(posedge core_clk) disable iff (!rstSync_n)
      waitDone |=> !busy && !coreStat[ST_BUSY];
   endproperty
   a_busy_bit: assert property (p_busy_bit) else $error("busy bit stuck");

   property p_read_start;
      @(posedge sck) disable iff (select_n)
      (byteDone && (byteCnt_ff == IDX_LAST_ADDR) && (opNow == OP_READ) && !aaiL) |=> outPhase_ff;
   endproperty
   a_read_start: assert property (p_read_start) else $error("read did not start");

   property p_fast_dummy;
      @(posedge sck) disable iff (select_n)
      ((op_ff == OP_FAST_READ) && (byteCnt_ff != 3'h0) && (byteCnt_ff <= IDX_DUMMY)) |-> !outPhase_ff;
   endproperty
   a_fast_dummy: assert property (p_fast_dummy) else $error("fast read output before dummy");

   property p_unknown;
      @(posedge sck) disable iff (select_n)
      ((byteCnt_ff != 3'h0) && (cmdLen(op_ff, aaiL) == LEN_NONE) && !isReadOp && !isIdentOp &&
       (op_ff != OP_STATUS_READ)) |-> !outPhase_ff;
   endproperty
   a_unknown: assert property (p_unknown) else $error("unknown opcode drove output");

endmodule : spi_flash_command_set
`default_nettype wire

//--- spi_host_model.sv
// Host model: drives the link in mode 0, sck idle low between frames.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output logic sck,
   output logic select_n,
   output logic serialIn,
   input wire logic serialOut,
   input wire logic serialOutEn
);
   initial begin
      sck = 1'b0;
      select_n = 1'b1;
      serialIn = 1'b0;
   end
   task automatic xfer(input logic [7:0] tx[$], input int nrx, output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      #7 select_n = 1'b0;
      for (int i = 0; i < tx.size() + nrx; i++) begin
         for (int k = 7; k >= 0; k--) begin
            serialIn = (i < tx.size()) ? tx[i][k] : ~serialIn;
            #15 sck = 1'b1;
            b[k] = serialOutEn ? serialOut : ~serialOut;
            #15 sck = 1'b0;
         end
         if (i >= tx.size()) rx.push_back(b);
      end
      #15 select_n = 1'b1;
      serialIn = ~serialIn;
      #60;
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

//--- sync_2ff.sv
// Two flip-flop level synchroniser, parameterised width and reset value.
// Assumes each bit is a slow level; words need stable source while sampled.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= RST_VAL;
         q_ff <= RST_VAL;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule : sync_2ff
`default_nettype wire

//--- tb_spi_flash_command_set.sv
// Self-checking bench: host model on the link, byte model of the array.
// Assumes small ADDR_W and PROG_CYC for a short run.
`timescale 1ns/1ps
`default_nettype none
module tb_spi_flash_command_set;
   import flash_cmd_pkg::*;
   localparam int AW = 10;
   logic core_clk, reset_n, sck, select_n, serialIn, serialOut, serialOutEn, busyStatus, unk;
   logic [2:0] protLevel;
   logic [7:0] mem [int];
   logic [7:0] rx [$], noTx [$];
   logic [7:0] d;
   logic [7:0] eraseOps [5] = '{OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE};
   int num_errors, cmp_count, a;
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   spi_flash_command_set #(.ADDR_W(AW), .PROG_CYC(20)) dut_u (.core_clk(core_clk), .reset_n(reset_n),
      .sck(sck), .select_n(select_n), .serialIn(serialIn), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .protLevel(protLevel), .busyStatus(busyStatus));
   spi_host_model host_u (.sck(sck), .select_n(select_n), .serialIn(serialIn), .serialOut(serialOut),
      .serialOutEn(serialOutEn));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wrap_up();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic cmd(input logic [7:0] tx[$], input int n);
      host_u.xfer(tx, n, rx);
   endtask : cmd
   task automatic wait_ready();
      for (int i = 0; i < 80; i++) begin
         cmd('{OP_STATUS_READ}, 1);
         if (rx[0][0] === 1'b0) return;
      end
      num_errors++;
      wrap_up();
   endtask : wait_ready
   task automatic rd(input logic [7:0] op, input int ad, input int n);
      if (op == OP_READ) cmd('{op, 8'h00, ad[15:8], ad[7:0]}, n);
      else cmd('{op, 8'h00, ad[15:8], ad[7:0], 8'h00}, n);
      for (int i = 0; i < n; i++) chk("read", mem[(ad + i) % (1 << AW)], rx[i]);
   endtask : rd
   task automatic prog(input int ad, input logic [7:0] v);
      cmd('{OP_BYTE_PROG, 8'h00, ad[15:8], ad[7:0], v}, 0);
   endtask : prog
   always @(posedge sck) if (unk) chk("oe", 8'h00, {7'h00, serialOutEn});
   initial begin
      reset_n = 1'b0;
      protLevel = 3'h0;
      unk = 1'b0;
      void'($urandom(32'h85af));
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      cmd('{OP_STATUS_READ}, 2);
      foreach (rx[i]) chk("status", 8'h00, rx[i]);
      for (int i = 0; i < 4; i++) begin
         cmd('{i[1] ? OP_IDENT_B : OP_IDENT_A, 8'h00, 8'h00, {7'h00, i[0]}}, 2);
         foreach (rx[j]) chk("ident", i[0] ? PART_CODE : MAKER_CODE, rx[j]);
      end
      unk = 1'b1;
      cmd('{8'h3a}, 1);
      unk = 1'b0;
      foreach (eraseOps[k]) begin
         cmd('{OP_WRITE_ENABLE}, 0);
         cmd('{OP_STATUS_READ}, 1);
         chk("status", 8'h02, rx[0]);
         if (k < 2) cmd('{eraseOps[k]}, 0);
         else cmd('{eraseOps[k], 8'h00, 8'h00, 8'h00}, 0);
         wait_ready();
         chk("status", 8'h00, rx[0]);
      end
      for (int i = 0; i < (1 << AW); i++) mem[i] = ERASED_BYTE;
      a = 64 + $urandom % ((1 << AW) - 64);
      d = 8'($urandom);
      prog(a, d);
      chk("busy", 8'h00, {7'h00, busyStatus});
      cmd('{OP_WRITE_ENABLE}, 0);
      protLevel <= 3'h4;
      repeat (4) @(posedge core_clk);
      prog(a, d);
      chk("busy", 8'h00, {7'h00, busyStatus});
      protLevel <= 3'h0;
      repeat (4) @(posedge core_clk);
      for (int k = 0; k < 2; k++) begin
         cmd('{OP_WRITE_ENABLE}, 0);
         prog(k ? 0 : a, d ^ k[7:0]);
         chk("busy", 8'h01, {7'h00, busyStatus});
         wait_ready();
         mem[k ? 0 : a] = d ^ k[7:0];
      end
      cmd('{OP_BUSY_OUT_EN}, 0);
      cmd('{OP_WRITE_ENABLE}, 0);
      cmd('{OP_AUTO_INC, 8'h00, 8'h00, 8'h20, d, ~d}, 0);
      host_u.xfer(noTx, 1, rx);
      chk("ready_busy_n", 8'h00, {7'h00, rx[0][7]});
      chk("ready_busy_n", 8'h01, {7'h00, rx[0][0]});
      cmd('{OP_AUTO_INC, ~d, d}, 0);
      cmd('{OP_WRITE_DISABLE}, 0);
      cmd('{OP_BUSY_OUT_DIS}, 0);
      mem[32] = d;
      mem[33] = ~d;
      mem[34] = ~d;
      mem[35] = d;
      rd(OP_READ, 32, 4);
      rd(OP_READ, a, 2);
      rd(OP_FAST_READ, a, 2);
      rd(OP_READ, (1 << AW) - 1, 2);
      wrap_up();
   end
endmodule : tb_spi_flash_command_set
`default_nettype wire
